// file: core/smcr_consts.svh
`ifndef SMCR_CONSTS_SVH
`define SMCR_CONSTS_SVH

// =====================================================================
// Register map
`define SMCR_CFG_ADDR 6'h1A
`define SMCR_CFG_RESET 24'h000000
`define SMCR_CFG_WMASK 24'h01FFFE
`define SMCR_RUN_SAFE_MASK 24'h000A00
`define SMCR_CSUM_W 16

// =====================================================================
// Field positions
`define SMCR_SINK_BIT 16
`define SMCR_DEB_HI 15
`define SMCR_DEB_LO 14
`define SMCR_SRC_BIT 13
`define SMCR_INT_BIT 12
`define SMCR_RUN_BIT 11
`define SMCR_POLL_BIT 10
`define SMCR_CSUM_BIT 9
`define SMCR_WIN_HI 8
`define SMCR_WIN_LO 5
`define SMCR_PER_HI 4
`define SMCR_PER_LO 1
`define SMCR_SWRST_BIT 0

// =====================================================================
// Timing
`define SMCR_CLK_PERIOD_NS 10
`define SMCR_US_NS 1000
`define SMCR_TICK_CYCLES \
  ((`SMCR_US_NS + `SMCR_CLK_PERIOD_NS - 1) / `SMCR_CLK_PERIOD_NS)
`define SMCR_MS_US 1000

`endif

// file: core/smcr_pkg.sv
package smcr_pkg;

  // ===================================================================
  // Sampling sequencer states.
  typedef enum logic [1:0] {
    SMCR_IDLE,
    SMCR_ACTIVE,
    SMCR_WAIT
  } smcr_state_t;

  // ===================================================================
  // Wetting window length in microseconds for a field code.
  function automatic logic [11:0] smcr_window_us(input logic [3:0] c);
    case (c)
      4'h0: smcr_window_us = 12'h040;
      4'h1: smcr_window_us = 12'h080;
      4'h2: smcr_window_us = 12'h0C0;
      4'h3: smcr_window_us = 12'h100;
      4'h4: smcr_window_us = 12'h140;
      4'h5: smcr_window_us = 12'h180;
      4'h6: smcr_window_us = 12'h1C0;
      4'h7: smcr_window_us = 12'h200;
      4'h8: smcr_window_us = 12'h280;
      4'h9: smcr_window_us = 12'h300;
      4'hA: smcr_window_us = 12'h380;
      4'hB: smcr_window_us = 12'h400;
      4'hC: smcr_window_us = 12'h800;
      default: smcr_window_us = 12'h200;
    endcase
  endfunction

  // Polling period in milliseconds for a field code.
  function automatic logic [12:0] smcr_period_ms(input logic [3:0] c);
    case (c)
      4'h0: smcr_period_ms = 13'h0002;
      4'h1: smcr_period_ms = 13'h0004;
      4'h2: smcr_period_ms = 13'h0008;
      4'h3: smcr_period_ms = 13'h0010;
      4'h4: smcr_period_ms = 13'h0020;
      4'h5: smcr_period_ms = 13'h0030;
      4'h6: smcr_period_ms = 13'h0040;
      4'h7: smcr_period_ms = 13'h0080;
      4'h8: smcr_period_ms = 13'h0100;
      4'h9: smcr_period_ms = 13'h0200;
      4'hA: smcr_period_ms = 13'h0400;
      4'hB: smcr_period_ms = 13'h0800;
      4'hC: smcr_period_ms = 13'h1000;
      default: smcr_period_ms = 13'h0008;
    endcase
  endfunction

endpackage

// file: core/smcr_sampler.sv
`timescale 1ns/1ps
`include "smcr_consts.svh"

module smcr_sampler #(
  parameter int TICK_CYCLES = `SMCR_TICK_CYCLES,
  parameter int MS_US = `SMCR_MS_US
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  input wire logic poll_i,
  input wire logic [3:0] win_code_i,
  input wire logic [3:0] per_code_i,
  output logic wetting_on_o,
  output logic sample_strobe_o
);
  import smcr_pkg::*;

  smcr_state_t state, next_state;
  logic [15:0] tick_cnt, next_tick_cnt;
  logic [15:0] ms_sub, next_ms_sub;
  logic [11:0] win_cnt, next_win_cnt;
  logic [12:0] per_cnt, next_per_cnt;
  logic next_wetting_on, next_sample_strobe;
  logic us_tick, ms_tick;

  // =====================================================================
  // Window and period sequencer; periods are timed from the window start.
  always_comb begin
    next_state = state;
    next_tick_cnt = tick_cnt;
    next_ms_sub = ms_sub;
    next_win_cnt = win_cnt;
    next_per_cnt = per_cnt;
    next_sample_strobe = 1'b0;
    us_tick = (tick_cnt == 16'(TICK_CYCLES - 1));
    ms_tick = us_tick && (ms_sub == 16'(MS_US - 1));
    if (state != SMCR_IDLE) begin
      next_tick_cnt = us_tick ? 16'h0000 : tick_cnt + 16'h0001;
      if (us_tick) begin
        next_ms_sub = ms_tick ? 16'h0000 : ms_sub + 16'h0001;
      end
      if (ms_tick && per_cnt != 13'h0000) begin
        next_per_cnt = per_cnt - 13'h0001;
      end
    end
    case (state)
      SMCR_IDLE: begin
        if (run_i) begin
          next_state = SMCR_ACTIVE;
          next_tick_cnt = 16'h0000;
          next_ms_sub = 16'h0000;
          next_win_cnt = smcr_window_us(win_code_i);
          next_per_cnt = smcr_period_ms(per_code_i);
        end
      end
      SMCR_ACTIVE: begin
        if (us_tick) begin
          next_win_cnt = win_cnt - 12'h001;
        end
        if (us_tick && win_cnt == 12'h001) begin
          next_sample_strobe = 1'b1;
          // Continuous mode starts the next window at once.
          if (!poll_i || next_per_cnt == 13'h0000) begin
            next_win_cnt = smcr_window_us(win_code_i);
            next_per_cnt = smcr_period_ms(per_code_i);
            next_ms_sub = 16'h0000;
          end else begin
            next_state = SMCR_WAIT;
          end
        end
      end
      SMCR_WAIT: begin
        if (next_per_cnt == 13'h0000) begin
          next_state = SMCR_ACTIVE;
          next_win_cnt = smcr_window_us(win_code_i);
          next_per_cnt = smcr_period_ms(per_code_i);
          next_ms_sub = 16'h0000;
        end
      end
      default: next_state = SMCR_IDLE;
    endcase
    if (!run_i) begin
      next_state = SMCR_IDLE;
      next_sample_strobe = 1'b0;
    end
    // Wetting current stays on between windows in continuous mode, or in polling mode if the period ran out within the window.
    next_wetting_on = (next_state == SMCR_ACTIVE);
  end

  // Registers of the sequencer.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= SMCR_IDLE;
      tick_cnt <= 16'h0000;
      ms_sub <= 16'h0000;
      win_cnt <= 12'h000;
      per_cnt <= 13'h0000;
      wetting_on_o <= 1'b0;
      sample_strobe_o <= 1'b0;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      ms_sub <= next_ms_sub;
      win_cnt <= next_win_cnt;
      per_cnt <= next_per_cnt;
      wetting_on_o <= next_wetting_on;
      sample_strobe_o <= next_sample_strobe;
    end
  end

endmodule

// file: core/smcr_top.sv
`timescale 1ns/1ps
`include "smcr_consts.svh"

module smcr_top #(
  parameter int TICK_CYCLES = `SMCR_TICK_CYCLES,
  parameter int MS_US = `SMCR_MS_US
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [23:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic temperature_warning_event_i,
  input wire logic checksum_done_i,
  input wire logic [`SMCR_CSUM_W-1:0] checksum_result_i,
  input wire logic flag_clear_i,
  input wire logic [23:0] raw_sample_i,
  output logic [23:0] reg_rdata_o,
  output logic run_o,
  output logic poll_mode_o,
  output logic int_dynamic_o,
  output logic sink_derate_o,
  output logic source_derate_o,
  output logic checksum_start_o,
  output logic checksum_busy_o,
  output logic checksum_done_flag_o,
  output logic [`SMCR_CSUM_W-1:0] checksum_result_o,
  output logic int_n_o,
  output logic soft_reset_o,
  output logic wetting_on_o,
  output logic sample_strobe_o,
  output logic [23:0] valid_sample_o
);
  import smcr_pkg::*;

  logic [23:0] cfg, next_cfg;
  logic [23:0] next_rdata;
  logic next_start, next_flag, next_soft_reset;
  logic [`SMCR_CSUM_W-1:0] next_result;
  logic tw_meta, tw_sync;
  logic [23:0] raw_meta, raw_sync;
  logic next_sink, next_source;
  logic wr_hit, swrst;
  logic [23:0] wmask;
  logic [23:0] last_smp, next_last_smp;
  logic [2:0] eq_cnt [24];
  logic [2:0] next_eq_cnt [24];
  logic [23:0] next_valid;
  logic [2:0] need;

  // =====================================================================
  // Configuration register write path.
  always_comb begin
    wr_hit = reg_wr_i && (reg_addr_i == `SMCR_CFG_ADDR);
    swrst = wr_hit && reg_wdata_i[`SMCR_SWRST_BIT];
    // A running device stores only the run and trigger bits; the rest waits
    // until software stops it, but a soft reset write still clears all and stops sampling.
    wmask = cfg[`SMCR_RUN_BIT] ? `SMCR_RUN_SAFE_MASK
                               : `SMCR_CFG_WMASK;
    next_cfg = cfg;
    next_start = 1'b0;
    if (wr_hit) begin
      // Reserved bits and the reset bit are never stored.
      next_cfg = (cfg & ~wmask) | (reg_wdata_i & wmask);
      // A write only sets the trigger bit; completion or a soft reset write clears it.
      next_cfg[`SMCR_CSUM_BIT] = cfg[`SMCR_CSUM_BIT] |
                                 reg_wdata_i[`SMCR_CSUM_BIT];
    end
    if (checksum_done_i) begin
      next_cfg[`SMCR_CSUM_BIT] = 1'b0;
    end
    // A fresh trigger in the cycle of completion is kept and restarted.
    if (wr_hit && reg_wdata_i[`SMCR_CSUM_BIT] &&
        (!cfg[`SMCR_CSUM_BIT] || checksum_done_i)) begin
      next_cfg[`SMCR_CSUM_BIT] = 1'b1;
      next_start = 1'b1;
    end
    if (swrst) begin
      next_cfg = `SMCR_CFG_RESET;
      next_start = 1'b0;
    end
    next_soft_reset = swrst;
  end

  // Configuration registers; all fields come up as zero.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cfg <= `SMCR_CFG_RESET;
      checksum_start_o <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      cfg <= next_cfg;
      checksum_start_o <= next_start;
      soft_reset_o <= next_soft_reset;
    end
  end

  // =====================================================================
  // Read path: one cycle after the read strobe, zero for other offsets.
  always_comb begin
    next_rdata = reg_rdata_o;
    if (reg_rd_i) begin
      next_rdata = (reg_addr_i == `SMCR_CFG_ADDR) ? cfg : 24'h000000;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 24'h000000;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  // =====================================================================
  // Checksum completion: sticky flag, active-low pin and result store.
  always_comb begin
    next_flag = checksum_done_flag_o;
    next_result = checksum_result_o;
    if (flag_clear_i || swrst) begin
      next_flag = 1'b0;
    end
    // Completion beats a clear in the same cycle, so no event is lost.
    if (checksum_done_i && cfg[`SMCR_CSUM_BIT]) begin
      next_flag = 1'b1;
      next_result = checksum_result_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      checksum_done_flag_o <= 1'b0;
      checksum_result_o <= '0;
      int_n_o <= 1'b1;
    end else begin
      checksum_done_flag_o <= next_flag;
      checksum_result_o <= next_result;
      int_n_o <= ~next_flag;
    end
  end

  // =====================================================================
  // Temperature warning and comparator results come from the analog side,
  // so both pass two flops before any logic reads them.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tw_meta <= 1'b0;
      tw_sync <= 1'b0;
      raw_meta <= 24'h000000;
      raw_sync <= 24'h000000;
    end else begin
      tw_meta <= temperature_warning_event_i;
      tw_sync <= tw_meta;
      raw_meta <= raw_sample_i;
      raw_sync <= raw_meta;
    end
  end

  // Derate commands to the front ends, applied only to 10 and 15 mA.
  always_comb begin
    next_sink = tw_sync && !next_cfg[`SMCR_SINK_BIT];
    next_source = tw_sync && !next_cfg[`SMCR_SRC_BIT];
  end

  // Plain control levels load from the same next value as the stored fields, so they match them with no delay.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sink_derate_o <= 1'b0;
      source_derate_o <= 1'b0;
      run_o <= 1'b0;
      poll_mode_o <= 1'b0;
      int_dynamic_o <= 1'b0;
      checksum_busy_o <= 1'b0;
    end else begin
      sink_derate_o <= next_sink;
      source_derate_o <= next_source;
      run_o <= next_cfg[`SMCR_RUN_BIT];
      poll_mode_o <= next_cfg[`SMCR_POLL_BIT];
      int_dynamic_o <= next_cfg[`SMCR_INT_BIT];
      checksum_busy_o <= next_cfg[`SMCR_CSUM_BIT];
    end
  end

  // =====================================================================
  // Sampling timer.
  smcr_sampler #(
    .TICK_CYCLES(TICK_CYCLES),
    .MS_US(MS_US)
  ) smcr_sampler_i (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .run_i(cfg[`SMCR_RUN_BIT]),
    .poll_i(cfg[`SMCR_POLL_BIT]),
    .win_code_i(cfg[`SMCR_WIN_HI:`SMCR_WIN_LO]),
    .per_code_i(cfg[`SMCR_PER_HI:`SMCR_PER_LO]),
    .wetting_on_o(wetting_on_o),
    .sample_strobe_o(sample_strobe_o)
  );

  // =====================================================================
  // Debounce: a bit is accepted once it repeats the chosen number of
  // times. The count saturates, so a long stable input stays valid.
  always_comb begin
    need = {1'b0, cfg[`SMCR_DEB_HI:`SMCR_DEB_LO]} + 3'h1;
    next_last_smp = last_smp;
    next_valid = valid_sample_o;
    for (int i = 0; i < 24; i++) begin
      next_eq_cnt[i] = eq_cnt[i];
      if (sample_strobe_o) begin
        if (raw_sync[i] == last_smp[i]) begin
          next_eq_cnt[i] = (eq_cnt[i] == 3'h4) ? 3'h4 : eq_cnt[i] + 3'h1;
        end else begin
          next_eq_cnt[i] = 3'h1;
        end
        next_last_smp[i] = raw_sync[i];
        if (next_eq_cnt[i] >= need) begin
          next_valid[i] = raw_sync[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || soft_reset_o) begin
      last_smp <= 24'h000000;
      valid_sample_o <= 24'h000000;
      for (int i = 0; i < 24; i++) begin
        eq_cnt[i] <= 3'h0;
      end
    end else begin
      last_smp <= next_last_smp;
      valid_sample_o <= next_valid;
      for (int i = 0; i < 24; i++) begin
        eq_cnt[i] <= next_eq_cnt[i];
      end
    end
  end

endmodule

// file: core/smcr_pad.sv
`timescale 1ns/1ps

// file: testbench/smcr_top_checker.sv
`timescale 1ns/1ps
`include "smcr_consts.svh"

// ==================
// Port checker for the configuration block; one clock, one reset.
module smcr_top_checker #(
  parameter int TICK_CYCLES = 1,
  parameter int MS_US = 2
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [23:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic temperature_warning_event_i,
  input wire logic checksum_done_i,
  input wire logic [`SMCR_CSUM_W-1:0] checksum_result_i,
  input wire logic [23:0] reg_rdata_o,
  input wire logic run_o,
  input wire logic poll_mode_o,
  input wire logic int_dynamic_o,
  input wire logic sink_derate_o,
  input wire logic source_derate_o,
  input wire logic checksum_start_o,
  input wire logic checksum_busy_o,
  input wire logic checksum_done_flag_o,
  input wire logic [`SMCR_CSUM_W-1:0] checksum_result_o,
  input wire logic int_n_o,
  input wire logic soft_reset_o,
  input wire logic wetting_on_o,
  input wire logic sample_strobe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // A write that reaches the configuration word.
  wire cfg_wr = reg_wr_i && reg_addr_i == `SMCR_CFG_ADDR;

  // Soft reset and checksum launch are multi-step, so named steps.
  sequence soft_kick;
    cfg_wr && reg_wdata_i[0];
  endsequence
  sequence soft_steps;
    soft_reset_o ##1 !run_o && !poll_mode_o && !checksum_done_flag_o;
  endsequence
  sequence csum_kick;
    cfg_wr && reg_wdata_i[9] && !reg_wdata_i[0] && !checksum_busy_o;
  endsequence

  // ==================
  // Run bit follows the word written one cycle earlier; mode and pin style only while stopped.
  run_write_a: assert property (
    cfg_wr && !reg_wdata_i[0] |=> run_o == $past(reg_wdata_i[11]))
    else $error("run bit did not follow the write");
  field_ctl_a: assert property (
    cfg_wr && !reg_wdata_i[0] && !run_o |=>
    poll_mode_o == $past(reg_wdata_i[10]) &&
    int_dynamic_o == $past(reg_wdata_i[12]))
    else $error("mode or pin style did not follow the write");
  derate_idle_a: assert property (
    !temperature_warning_event_i [*5] |->
    !sink_derate_o && !source_derate_o)
    else $error("derate without a temperature warning");
  csum_start_a: assert property (
    csum_kick |=> checksum_start_o && checksum_busy_o)
    else $error("checksum did not start");
  csum_done_a: assert property (
    checksum_busy_o && checksum_done_i && !cfg_wr |=>
    checksum_done_flag_o && !int_n_o && !checksum_busy_o &&
    checksum_result_o == $past(checksum_result_i))
    else $error("checksum completion not reported");
  csum_hold_a: assert property (
    checksum_busy_o && !checksum_done_i &&
    !(cfg_wr && reg_wdata_i[0]) |=> checksum_busy_o)
    else $error("running checksum was dropped");
  pin_flag_a: assert property (
    int_n_o == !checksum_done_flag_o)
    else $error("interrupt pin disagrees with done flag");
  soft_rst_a: assert property (
    soft_kick |=> soft_steps)
    else $error("soft reset did not clear the block");
  rd_reserved_a: assert property (
    reg_rd_i |=> reg_rdata_o[23:17] == 7'h00 && !reg_rdata_o[0])
    else $error("reserved bits read nonzero");
  run_idle_a: assert property (
    !run_o [*3] |-> !wetting_on_o && !sample_strobe_o)
    else $error("sampling while stopped");
endmodule

bind smcr_top smcr_top_checker #(.TICK_CYCLES(TICK_CYCLES),
  .MS_US(MS_US)) smcr_top_checker_i (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .temperature_warning_event_i(temperature_warning_event_i),
  .checksum_done_i(checksum_done_i),
  .checksum_result_i(checksum_result_i),
  .reg_rdata_o(reg_rdata_o), .run_o(run_o), .poll_mode_o(poll_mode_o),
  .int_dynamic_o(int_dynamic_o), .sink_derate_o(sink_derate_o),
  .source_derate_o(source_derate_o),
  .checksum_start_o(checksum_start_o),
  .checksum_busy_o(checksum_busy_o),
  .checksum_done_flag_o(checksum_done_flag_o),
  .checksum_result_o(checksum_result_o), .int_n_o(int_n_o),
  .soft_reset_o(soft_reset_o), .wetting_on_o(wetting_on_o),
  .sample_strobe_o(sample_strobe_o));

// file: testbench/smcr_commander.sv
`timescale 1ns/1ps
`include "smcr_consts.svh"

// ==================
// Host model: one access at a time, with an idle gap for a slow host.
module smcr_commander (
  input wire logic clk_sys_i,
  output logic [5:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [23:0] reg_wdata_o,
  output logic reg_rd_o
);
  int gap = 0;
  logic [23:0] shadow = 24'h000000;

  // Strobes are low from time zero.
  initial begin
    reg_addr_o = 6'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 24'h000000;
    reg_rd_o = 1'b0;
  end

  // One access; a released bus shows the inverse of its last value.
  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [23:0] d);
    @(posedge clk_sys_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = w;
    reg_rd_o = !w;
    @(posedge clk_sys_i);
    #1;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
    repeat (gap) @(posedge clk_sys_i);
  endtask

  // Settings change only while stopped, which avoids false status.
  task automatic cfg(input logic [23:0] d);
    logic [23:0] s;
    s = shadow;
    s[11] = 1'b0;
    acc(1'b1, `SMCR_CFG_ADDR, s);
    acc(1'b1, `SMCR_CFG_ADDR, {d[23:12], 1'b0, d[10:0]});
    if (d[11]) begin
      acc(1'b1, `SMCR_CFG_ADDR, d);
    end
    shadow = d;
  endtask
endmodule

// file: testbench/smcr_top_test.sv
`timescale 1ns/1ps
`include "smcr_consts.svh"

module smcr_top_test;
  localparam int TICK = 1;
  localparam int MSU = 16;
  localparam logic [5:0] CFG = `SMCR_CFG_ADDR;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic temperature_warning_event_i = 1'b0;
  logic checksum_done_i = 1'b0;
  logic [`SMCR_CSUM_W-1:0] checksum_result_i = 16'h0000;
  logic flag_clear_i = 1'b0;
  logic [23:0] raw_sample_i = 24'h000000;
  logic [5:0] reg_addr_i;
  logic reg_wr_i, reg_rd_i, run_o, poll_mode_o, int_dynamic_o;
  logic [23:0] reg_wdata_i, reg_rdata_o, valid_sample_o;
  logic [`SMCR_CSUM_W-1:0] checksum_result_o;
  logic sink_derate_o, source_derate_o, checksum_start_o;
  logic checksum_busy_o, checksum_done_flag_o, int_n_o;
  logic soft_reset_o, wetting_on_o, sample_strobe_o;
  logic rd_seen = 1'b0;
  logic [23:0] exp_q[$];
  int num_errors = 0;
  int tests_run = 0;
  logic [23:0] mode_w[11] = '{24'h000800, 24'h0008E0, 24'h000900,
    24'h000960, 24'h000980, 24'h0009A0, 24'h0009E0, 24'h000C06,
    24'h000C0A, 24'h000C1A, 24'h000C1E};
  int mode_n[11] = '{64, 512, 640, 1024, 2048, 512, 512, 16, 48, 8, 8};

  // ==================
  // Clock, design and host model.
  always #5 clk_sys_i = ~clk_sys_i;
  smcr_top #(.TICK_CYCLES(TICK), .MS_US(MSU)) smcr_top_i (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .temperature_warning_event_i(temperature_warning_event_i),
    .checksum_done_i(checksum_done_i),
    .checksum_result_i(checksum_result_i),
    .flag_clear_i(flag_clear_i), .raw_sample_i(raw_sample_i),
    .reg_rdata_o(reg_rdata_o), .run_o(run_o), .poll_mode_o(poll_mode_o),
    .int_dynamic_o(int_dynamic_o), .sink_derate_o(sink_derate_o),
    .source_derate_o(source_derate_o),
    .checksum_start_o(checksum_start_o),
    .checksum_busy_o(checksum_busy_o),
    .checksum_done_flag_o(checksum_done_flag_o),
    .checksum_result_o(checksum_result_o), .int_n_o(int_n_o),
    .soft_reset_o(soft_reset_o), .wetting_on_o(wetting_on_o),
    .sample_strobe_o(sample_strobe_o), .valid_sample_o(valid_sample_o));
  smcr_commander smcr_commander_i (.clk_sys_i(clk_sys_i),
    .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));

  // ==================
  // Helpers.
  task automatic cmp(input string what, input logic [23:0] e,
                     input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic tick;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    exp_q.push_back(e);
    smcr_commander_i.acc(1'b0, a, 24'h000000);
  endtask
  // Bounded wait for the next strobe; n returns the cycles waited.
  task automatic next_strobe(output int n);
    n = 0;
    do begin
      tick();
      n++;
    end while (sample_strobe_o !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Read data lands one cycle after the read; the oldest note is used.
  always @(posedge clk_sys_i) begin
    if (rd_seen && exp_q.size() > 0) begin
      cmp("read data", exp_q.pop_front(), reg_rdata_o);
    end
    rd_seen <= reg_rd_i;
  end

  // ==================
  // Main sequence.
  initial begin
    int n, m, e;
    logic [23:0] w, v;
    w = $urandom(32'hE44B4F55);
    repeat (5) @(posedge clk_sys_i);
    #1;
    sys_rst_i = 1'b0;
    rd(CFG, 24'h000000);
    cmp("idle pins", 24'h000001, {run_o, poll_mode_o, checksum_busy_o,
      checksum_done_flag_o, int_n_o});
    // Random readback through a slow host, then an unmapped place.
    smcr_commander_i.gap = 2;
    repeat (4) begin
      w = $urandom & 24'hFFF5FE;
      smcr_commander_i.cfg(w);
      rd(CFG, w & `SMCR_CFG_WMASK);
    end
    smcr_commander_i.gap = 0;
    smcr_commander_i.acc(1'b1, 6'h1B, ~w);
    rd(6'h1B, 24'h000000);
    rd(CFG, w & `SMCR_CFG_WMASK);
    // Every derate setting under a temperature warning.
    for (int k = 0; k < 4; k++) begin
      smcr_commander_i.cfg({7'h00, k[1], 2'b00, k[0], 13'h0000});
      temperature_warning_event_i = 1'b1;
      repeat (5) tick();
      cmp("derate", {22'h0, !k[1], !k[0]},
        {22'h0, sink_derate_o, source_derate_o});
      temperature_warning_event_i = 1'b0;
    end
    // Window and period codes, window boundary codes and fallback codes of both included.
    foreach (mode_w[i]) begin
      smcr_commander_i.cfg(mode_w[i]);
      next_strobe(n);
      next_strobe(n);
      e = mode_w[i][10] ? mode_n[i] * MSU * TICK : mode_n[i] * TICK;
      cmp("strobe gap", 24'(e), 24'(n));
      cmp("wetting", {23'h0, !mode_w[i][10]},
        {23'h0, wetting_on_o});
    end
    // Debounce depth: strobes needed before a new value is taken.
    for (int d = 0; d < 4; d++) begin
      smcr_commander_i.cfg({8'h00, d[1:0], 14'h0800});
      w = $urandom;
      raw_sample_i = w;
      repeat (5) next_strobe(n);
      cmp("settled", w, valid_sample_o);
      raw_sample_i = ~w;
      m = 0;
      while (valid_sample_o !== ~w && m < 6) begin
        next_strobe(n);
        tick();
        m++;
      end
      cmp("debounce", 24'(d + 1), 24'(m));
    end
    // Checksum while running; other bits stay protected meanwhile.
    v = $urandom & 24'h01F5FE;
    smcr_commander_i.cfg(v | 24'h000800);
    smcr_commander_i.acc(1'b1, CFG, v | 24'h000A00);
    rd(CFG, v | 24'h000A00);
    // Only a zero goes to the trigger while the engine works, so no
    // setting changes under the calculation.
    smcr_commander_i.acc(1'b1, CFG, v | 24'h000800);
    rd(CFG, v | 24'h000A00);
    tick();
    checksum_done_i = 1'b1;
    checksum_result_i = w[15:0];
    tick();
    checksum_done_i = 1'b0;
    cmp("checksum", {2'b10, w[15:0]}, {checksum_done_flag_o, int_n_o,
      checksum_result_o});
    flag_clear_i = 1'b1;
    tick();
    flag_clear_i = 1'b0;
    cmp("flag", 24'h000001, {checksum_done_flag_o, int_n_o});
    rd(CFG, v | 24'h000800);
    smcr_commander_i.acc(1'b1, CFG, (~v & 24'h01F5FE) | 24'h000800);
    rd(CFG, v | 24'h000800);
    smcr_commander_i.acc(1'b1, CFG, v);
    rd(CFG, v);
    smcr_commander_i.acc(1'b1, CFG, 24'h000001);
    repeat (2) tick();
    rd(CFG, 24'h000000);
    cmp("soft reset", 24'h000000, valid_sample_o);
    repeat (3) tick();
    end_of_test();
  end
endmodule
